// ==== src/msd_pkg.sv ====
// Purpose: constants for the move-with-shift decode and execute block
// Assumes: 16-bit halfwords, 32-bit data path
// Notes: encodings of the narrow and wide move/shift forms
package msd_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] PC_IDX = 4'hf;
  localparam logic [1:0] SH_LSL = 2'h0;
  localparam logic [1:0] SH_LSR = 2'h1;
  localparam logic [1:0] SH_ASR = 2'h2;
  localparam logic [1:0] SH_ROR = 2'h3;
  // narrow register-shifted operation codes
  localparam logic [3:0] NOP_LSL = 4'h2;
  localparam logic [3:0] NOP_LSR = 4'h3;
  localparam logic [3:0] NOP_ASR = 4'h4;
  localparam logic [3:0] NOP_ROR = 4'h7;
  // opcode prefixes
  localparam logic [5:0] PFX_MOV_HI = 6'h11;  // 010001 10 -> bits 15:10 with 9:8 = 2'h2
  localparam logic [1:0] PFX_MOV_HI_LO = 2'h2;
  localparam logic [2:0] PFX_IMM_SH = 3'h0;
  localparam logic [5:0] PFX_REG_SH = 6'h10;
  localparam logic [10:0] PFX_W_IMM = 11'h752;  // 11101010010 + S + 1111
  localparam logic [3:0] W_RN_ONES = 4'hf;
  localparam logic [7:0] PFX_W_REG = 8'hfa;
  localparam logic [1:0] W_REG_TOP = 2'h0;
  localparam logic [3:0] W_REG_LOW = 4'h0;
  localparam int unsigned AMT_W = 8;
  localparam logic [7:0] AMT_WORD = 8'h20;
  // decoded form
  typedef enum logic [2:0] {
    MSD_NONE = 3'h0,
    MSD_MOV_HI = 3'h1,
    MSD_NIMM = 3'h3,
    MSD_WIMM = 3'h2,
    MSD_NREG = 3'h6,
    MSD_WREG = 3'h7
  } msd_form_e;
endpackage

// ==== src/msd_move_shift.sv ====
// Purpose: decode and execute the register move family with optional shift
// Assumes: one instruction per cycle when instr_valid; operands come from the register file read ports
// Notes: results are registered; one cycle from instr_valid to wr_valid / flags update
//
// Functional notes
// - narrow immediate-shift selector 00 left logical, 01 right logical, 10 right arithmetic.
// - wide immediate-shift kind 00 lsl, 01 lsr, 10 asr, 11 ror.
// - narrow amount field is amount mod 32; zero means 32 for right shifts.
// - wide amount is high three bits joined with low two bits, same modulo rule.
// - first narrow move uses high bit plus three bits; pc destination branches.
// - on condition pass shift source using current carry, yielding result and carry.
// - destination 15 of an immediate form writes through pc path and never updates flags.
// - flag setting sets n, z, c from result and shifter; v unchanged.
// - narrow register opcodes 0100 asr, 0010 lsl, 0011 lsr, 0111 ror; flags outside block.
// - narrow register form uses one field as source and destination, another as count.
// - wide register form sets flags when s is 1, kind from two-bit field.
// - register shifted moves use only the low eight bits of the count register.
// - register shifted moves write destination, never branch.
`timescale 1ns/1ps
module msd_move_shift #(
  parameter int unsigned DW = msd_pkg::DATA_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic instr_wide,
  input wire logic cond_pass,
  input wire logic in_cond_block,
  input wire logic last_in_cond_block,
  input wire logic [DW-1:0] source_reg_value,
  input wire logic [DW-1:0] shift_count_reg_value,
  input wire logic [3:0] app_status_flags,
  output logic [3:0] source_reg_field,
  output logic [3:0] shift_count_reg_field,
  output logic wr_valid_ff,
  output logic [3:0] wr_idx_ff,
  output logic [DW-1:0] wr_data_ff,
  output logic pc_write_ff,
  output logic [DW-1:0] pc_data_ff,
  output logic flags_we_ff,
  output logic [3:0] flags_ff,
  output logic unpredictable_ff,
  output logic undecoded_ff
);
  // flags are {n, z, c, v}
  logic [15:0] hw;
  logic [15:0] hw2;
  msd_pkg::msd_form_e form;
  logic [1:0] kind;
  logic [7:0] amount;
  logic imm_form;
  logic set_flags;
  logic [3:0] dst;
  logic [DW-1:0] sh_res;
  logic sh_carry;
  logic [4:0] narrow_amount_field;
  logic [2:0] amount_high_field;
  logic [1:0] amount_low_field;
  logic [1:0] shift_selector_field;
  logic [3:0] nreg_op;
  logic nxt_wr_valid;
  logic [3:0] nxt_wr_idx;
  logic [DW-1:0] nxt_wr_data;
  logic nxt_pc_write;
  logic [DW-1:0] nxt_pc_data;
  logic nxt_flags_we;
  logic [3:0] nxt_flags;
  logic nxt_unpred;
  logic nxt_undec;
  logic take;
  logic to_pc;

  // shifter with carry; count already in 0..255 form
  function automatic logic [DW:0] shift_c(input logic [DW-1:0] v, input logic [1:0] k,
                                          input logic [7:0] n, input logic cin);
    logic [2*DW-1:0] ext;
    logic [DW:0] r;
    logic [7:0] m;
    ext = '0;
    r = '0;
    m = '0;
    if (n == 8'h00) begin
      r = {v, cin};
    end else begin
      unique case (k)
        msd_pkg::SH_LSL: begin
          if (n > msd_pkg::AMT_WORD) r = {{DW{1'b0}}, 1'b0};
          else if (n == msd_pkg::AMT_WORD) r = {{DW{1'b0}}, v[0]};
          else begin
            ext = {{DW{1'b0}}, v} << n;
            r = {ext[DW-1:0], ext[DW]};
          end
        end
        msd_pkg::SH_LSR, msd_pkg::SH_ASR: begin
          if (n >= msd_pkg::AMT_WORD) begin
            if (k == msd_pkg::SH_ASR) r = {{DW{v[DW-1]}}, v[DW-1]};
            else r = {{DW{1'b0}}, (n == msd_pkg::AMT_WORD) ? v[DW-1] : 1'b0};
          end else begin
            ext = {(k == msd_pkg::SH_ASR) ? {DW{v[DW-1]}} : {DW{1'b0}}, v} >> (n - 8'h01);
            r = {ext[DW:1], ext[0]};
          end
        end
        msd_pkg::SH_ROR: begin
          m = n & 8'h1f;
          ext = {v, v} >> m;
          r = {ext[DW-1:0], ext[DW-1]};
        end
      endcase
    end
    return r;
  endfunction

  // pc index test, shared by every form that can name the pc
  function automatic logic is_pc(input logic [3:0] idx);
    return idx == msd_pkg::PC_IDX;
  endfunction

  assign hw = instr[15:0];
  assign hw2 = instr[31:16];

  always_comb begin
    form = msd_pkg::MSD_NONE;
    kind = msd_pkg::SH_LSL;
    amount = '0;
    imm_form = 1'b0;
    set_flags = 1'b0;
    dst = '0;
    source_reg_field = '0;
    shift_count_reg_field = '0;
    narrow_amount_field = hw[10:6];
    amount_high_field = hw2[14:12];
    amount_low_field = hw2[7:6];
    shift_selector_field = hw[12:11];
    nreg_op = hw[9:6];
    nxt_unpred = 1'b0;
    if (!instr_wide) begin
      if (hw[15:10] == msd_pkg::PFX_MOV_HI && hw[9:8] == msd_pkg::PFX_MOV_HI_LO) begin
        form = msd_pkg::MSD_MOV_HI;
        dst = {hw[7], hw[2:0]};
        source_reg_field = hw[6:3];
        imm_form = 1'b1;
        // caller must keep pc moves out of a block unless last
        nxt_unpred = is_pc(dst) && in_cond_block && !last_in_cond_block;
      end else if (hw[15:13] == msd_pkg::PFX_IMM_SH && shift_selector_field != msd_pkg::SH_ROR) begin
        form = msd_pkg::MSD_NIMM;
        kind = shift_selector_field;
        // zero field means 32 for right shifts, zero for left
        amount = (narrow_amount_field == 5'h00 && kind != msd_pkg::SH_LSL) ? msd_pkg::AMT_WORD
                 : {3'h0, narrow_amount_field};
        dst = {1'b0, hw[2:0]};
        source_reg_field = {1'b0, hw[5:3]};
        imm_form = 1'b1;
        set_flags = !in_cond_block;
        nxt_unpred = kind == msd_pkg::SH_LSL && narrow_amount_field == 5'h00 && in_cond_block;
      end else if (hw[15:10] == msd_pkg::PFX_REG_SH &&
                   (nreg_op == msd_pkg::NOP_ASR || nreg_op == msd_pkg::NOP_LSL ||
                    nreg_op == msd_pkg::NOP_LSR || nreg_op == msd_pkg::NOP_ROR)) begin
        form = msd_pkg::MSD_NREG;
        unique case (nreg_op)
          msd_pkg::NOP_ASR: kind = msd_pkg::SH_ASR;
          msd_pkg::NOP_LSL: kind = msd_pkg::SH_LSL;
          msd_pkg::NOP_LSR: kind = msd_pkg::SH_LSR;
          default: kind = msd_pkg::SH_ROR;
        endcase
        dst = {1'b0, hw[2:0]};
        source_reg_field = {1'b0, hw[2:0]};
        shift_count_reg_field = {1'b0, hw[5:3]};
        set_flags = !in_cond_block;
      end
    end else begin
      if (hw[15:5] == msd_pkg::PFX_W_IMM && hw[3:0] == W_ONES() && !hw2[15]) begin
        form = msd_pkg::MSD_WIMM;
        kind = hw2[5:4];
        amount = {3'h0, amount_high_field, amount_low_field};
        if (amount == 8'h00 && kind != msd_pkg::SH_LSL) begin
          // rotate with zero amount is the extend-rotate, treated as one-bit rotate through carry
          amount = (kind == msd_pkg::SH_ROR) ? 8'h00 : msd_pkg::AMT_WORD;
        end
        dst = hw2[11:8];
        source_reg_field = hw2[3:0];
        imm_form = 1'b1;
        set_flags = hw[4];
        nxt_unpred = is_pc(source_reg_field);
      end else if (hw[15:8] == msd_pkg::PFX_W_REG && hw[7] == 1'b0 && hw2[15:12] == msd_pkg::W_RN_ONES &&
                   hw2[7:4] == msd_pkg::W_REG_LOW) begin
        form = msd_pkg::MSD_WREG;
        kind = hw[6:5];
        set_flags = hw[4];
        source_reg_field = hw[3:0];
        dst = hw2[11:8];
        shift_count_reg_field = hw2[3:0];
        nxt_unpred = is_pc(dst) || is_pc(source_reg_field) ||
                     is_pc(shift_count_reg_field);
      end
    end
    if (form == msd_pkg::MSD_NREG || form == msd_pkg::MSD_WREG) begin
      amount = shift_count_reg_value[msd_pkg::AMT_W-1:0];
    end
  end

  function automatic logic [3:0] W_ONES();
    return msd_pkg::W_RN_ONES;
  endfunction

  always_comb begin
    logic [DW:0] rc;
    rc = '0;
    if (form == msd_pkg::MSD_WIMM && kind == msd_pkg::SH_ROR && amount == 8'h00) begin
      rc = {app_status_flags[1], source_reg_value[DW-1:1], source_reg_value[0]};
    end else begin
      rc = shift_c(source_reg_value, kind, amount, app_status_flags[1]);
    end
    sh_res = rc[DW:1];
    sh_carry = rc[0];
  end

  // executes only when decoded and the condition passed
  assign take = instr_valid && cond_pass && form != msd_pkg::MSD_NONE;
  // register-shifted forms never branch, so only immediate forms reach the pc
  assign to_pc = imm_form && is_pc(dst);

  // register write group
  always_comb begin
    nxt_wr_valid = take && !to_pc;
    nxt_wr_idx = dst;
    nxt_wr_data = sh_res;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_valid_ff <= 1'b0;
      wr_idx_ff <= '0;
      wr_data_ff <= '0;
    end else begin
      wr_valid_ff <= nxt_wr_valid;
      wr_idx_ff <= nxt_wr_idx;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // branch group; target holds until the next pc write
  always_comb begin
    nxt_pc_write = take && to_pc;
    nxt_pc_data = pc_data_ff;
    if (take && to_pc) begin
      nxt_pc_data = sh_res;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_write_ff <= 1'b0;
      pc_data_ff <= '0;
    end else begin
      pc_write_ff <= nxt_pc_write;
      pc_data_ff <= nxt_pc_data;
    end
  end

  // flag group; pc writes and the plain high-register move leave flags alone
  always_comb begin
    nxt_flags_we = take && !to_pc && set_flags && form != msd_pkg::MSD_MOV_HI;
    nxt_flags = flags_ff;
    if (nxt_flags_we) begin
      nxt_flags = {sh_res[DW-1], sh_res == '0, sh_carry, app_status_flags[0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_we_ff <= 1'b0;
      flags_ff <= '0;
    end else begin
      flags_we_ff <= nxt_flags_we;
      flags_ff <= nxt_flags;
    end
  end

  // status group; unpredictable encodings still execute
  always_comb begin
    nxt_undec = instr_valid && form == msd_pkg::MSD_NONE;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      unpredictable_ff <= 1'b0;
      undecoded_ff <= 1'b0;
    end else begin
      unpredictable_ff <= instr_valid && nxt_unpred;
      undecoded_ff <= nxt_undec;
    end
  end
endmodule

// ==== testbench/msd_move_shift_sva.sv ====
// Purpose: port-level checks for the move-with-shift block
// Assumes: single clock, synchronous active-high reset
// Notes: results are expected one cycle after the take edge
`timescale 1ns/1ps
module msd_move_shift_sva (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic instr_wide,
  input wire logic cond_pass,
  input wire logic in_cond_block,
  input wire logic [3:0] app_status_flags,
  input wire logic [3:0] source_reg_field,
  input wire logic [3:0] shift_count_reg_field,
  input wire logic wr_valid_ff,
  input wire logic [31:0] wr_data_ff,
  input wire logic pc_write_ff,
  input wire logic flags_we_ff,
  input wire logic [3:0] flags_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic go;
  logic nreg;
  logic wreg;
  assign go = instr_valid && cond_pass;
  assign nreg = !instr_wide && instr[15:10] == 6'h10 && instr[9:6] inside {4'h2, 4'h3, 4'h4, 4'h7};
  assign wreg = instr_wide && instr[15:7] == 9'h1f4 && instr[31:28] == 4'hf && instr[23:20] == 4'h0;
  property p_cond_fail;
    instr_valid && !cond_pass |=> !wr_valid_ff && !pc_write_ff && !flags_we_ff;
  endproperty
  a_cond_fail: assert property (p_cond_fail) else $error("write after failed condition");
  property p_pc_noflag;
    pc_write_ff |-> !flags_we_ff && !wr_valid_ff;
  endproperty
  a_pc_noflag: assert property (p_pc_noflag) else $error("flags or reg write with pc write");
  property p_answer;
    wr_valid_ff || flags_we_ff || pc_write_ff |-> $past(go);
  endproperty
  a_answer: assert property (p_answer) else $error("result without a taken instruction");
  property p_v_keep;
    flags_we_ff |-> flags_ff[0] == $past(app_status_flags[0]);
  endproperty
  a_v_keep: assert property (p_v_keep) else $error("overflow flag changed");
  property p_nz;
    flags_we_ff |-> flags_ff[3] == wr_data_ff[31] && flags_ff[2] == (wr_data_ff == 32'h0);
  endproperty
  a_nz: assert property (p_nz) else $error("negative or zero flag wrong");
  property p_nreg_blk;
    go && nreg |=> flags_we_ff == !$past(in_cond_block) && wr_valid_ff;
  endproperty
  a_nreg_blk: assert property (p_nreg_blk) else $error("narrow register form flag enable wrong");
  property p_fields;
    nreg |-> source_reg_field == {1'b0, instr[2:0]} && shift_count_reg_field == {1'b0, instr[5:3]};
  endproperty
  a_fields: assert property (p_fields) else $error("narrow register form read index wrong");
  property p_wide_s;
    go && wreg |=> flags_we_ff == $past(instr[4]) && wr_valid_ff && !pc_write_ff;
  endproperty
  a_wide_s: assert property (p_wide_s) else $error("wide register form write or flags wrong");
endmodule
bind msd_move_shift msd_move_shift_sva u_sva (.*);

// ==== testbench/test_move_shift_decode_execute.sv ====
// Purpose: directed test of the move-with-shift block
// Assumes: inputs change at the falling edge
// Notes: expected shift results come from a local model
`timescale 1ns/1ps
module test_move_shift_decode_execute;
  logic core_clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, instr_wide = 1'b0;
  logic cond_pass = 1'b1, in_cond_block = 1'b0, last_in_cond_block = 1'b0;
  logic [31:0] instr = 32'h0, source_reg_value = 32'h8000_0001, shift_count_reg_value = 32'h0;
  logic [3:0] app_status_flags = 4'h3;
  logic [3:0] source_reg_field, shift_count_reg_field, wr_idx_ff, flags_ff;
  logic [31:0] wr_data_ff, pc_data_ff;
  logic wr_valid_ff, pc_write_ff, flags_we_ff, unpredictable_ff, undecoded_ff;
  logic [4:0] am [3] = '{5'h0, 5'h1, 5'h1f};
  logic [3:0] op [4] = '{4'h2, 4'h3, 4'h4, 4'h7};
  logic [31:0] cn [3] = '{32'h0, 32'h21, 32'h120};
  int err_total = 0, samples_checked = 0;
  msd_move_shift u_dut (.*);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic close_out;
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // n below zero means rotate-through-carry by one
  function automatic logic [32:0] ref_sh(input logic [31:0] v, input logic [1:0] k, input int n, input logic c);
    logic [63:0] x;
    if (n < 0) return {v[0], c, v[31:1]};
    if (n == 0) return {c, v};
    case (k)
      2'h0: x = {32'h0, v} << n;
      2'h1: x = {v, 32'h0} >> n;
      2'h2: x = $signed({v, 32'h0}) >>> n;
      default: x = {v, v} >> (n % 32);
    endcase
    return (k == 2'h0) ? {x[32], x[31:0]} : (k == 2'h3) ? {x[31], x[31:0]} : {x[31], x[63:32]};
  endfunction
  // valid stays high so consecutive calls run back to back
  task automatic run(input logic [31:0] ins, input logic w, input logic [3:0] m, input logic [1:0] k, input int n,
                     input logic [3:0] d, input logic sf);
    logic [32:0] e;
    logic pc;
    e = ref_sh(source_reg_value, k, n, app_status_flags[1]);
    pc = d == 4'hf;
    instr = ins;
    instr_wide = w;
    instr_valid = 1'b1;
    #1 chk(source_reg_field, m);
    @(negedge core_clk);
    chk(pc_write_ff, cond_pass && pc);
    chk(wr_valid_ff, cond_pass && !pc);
    chk(flags_we_ff, cond_pass && sf && !pc);
    if (cond_pass && pc) chk(pc_data_ff, e[31:0]);
    if (cond_pass && !pc) chk({wr_idx_ff, wr_data_ff[27:0]}, {d, e[27:0]});
    if (cond_pass && !pc) chk(wr_data_ff, e[31:0]);
    if (cond_pass && sf && !pc) chk(flags_ff, {e[31], e[31:0] == 32'h0, e[32], app_status_flags[0]});
  endtask
  initial begin
    #200us;
    err_total++;
    close_out();
  end
  initial begin
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    for (int k = 0; k < 3; k++)
      foreach (am[i]) run({16'h0, 3'h0, k[1:0], am[i], 3'h2, 3'h5}, 1'b0, 4'h2, k[1:0],
          (am[i] == 5'h0 && k != 0) ? 32 : am[i], 4'h5, 1'b1);
    for (int k = 0; k < 4; k++)
      foreach (am[i]) run({1'b0, am[i][4:2], 4'h9, am[i][1:0], k[1:0], 4'h3, 16'hea5f}, 1'b1, 4'h3, k[1:0],
          am[i] != 5'h0 ? am[i] : k == 0 ? 0 : k == 3 ? -1 : 32, 4'h9, 1'b1);
    run({1'b0, 3'h0, 4'hf, 2'h1, 2'h1, 4'h3, 16'hea5f}, 1'b1, 4'h3, 2'h1, 1, 4'hf, 1'b1);
    run({16'h0, 8'h46, 1'b1, 4'h4, 3'h7}, 1'b0, 4'h4, 2'h0, 0, 4'hf, 1'b0);
    chk(unpredictable_ff, 1'b0);
    run({16'h0, 8'h46, 1'b1, 4'h4, 3'h2}, 1'b0, 4'h4, 2'h0, 0, 4'ha, 1'b0);
    app_status_flags = 4'h4;
    foreach (op[j])
      foreach (cn[i]) begin
        shift_count_reg_value = cn[i] + j;
        run({16'h0, 6'h10, op[j], 3'h6, 3'h1}, 1'b0, 4'h1, j[1:0], cn[i][7:0] + j, 4'h1, 1'b1);
        chk(shift_count_reg_field, 4'h6);
      end
    in_cond_block = 1'b1;
    shift_count_reg_value = 32'h1;
    run({16'h0, 6'h10, 4'h7, 3'h6, 3'h1}, 1'b0, 4'h1, 2'h3, 1, 4'h1, 1'b0);
    run({16'h0, 3'h0, 2'h0, 5'h1, 3'h2, 3'h5}, 1'b0, 4'h2, 2'h0, 1, 4'h5, 1'b0);
    run({16'h0, 3'h0, 2'h0, 5'h0, 3'h2, 3'h5}, 1'b0, 4'h2, 2'h0, 0, 4'h5, 1'b0);
    chk(unpredictable_ff, 1'b1);
    in_cond_block = 1'b0;
    shift_count_reg_value = 32'h105;
    for (int k = 0; k < 4; k++)
      run({4'hf, 4'h8, 4'h0, 4'h4, 8'hfa, 1'b0, k[1:0], k[0], 4'h3}, 1'b1, 4'h3, k[1:0], 5, 4'h8, k[0]);
    cond_pass = 1'b0;
    run({16'h0, 3'h0, 2'h1, 5'h3, 3'h2, 3'h5}, 1'b0, 4'h2, 2'h1, 3, 4'h5, 1'b1);
    cond_pass = 1'b1;
    instr = 32'h1c00;
    instr_wide = 1'b0;
    @(negedge core_clk);
    chk({undecoded_ff, wr_valid_ff}, 32'h2);
    instr_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    close_out();
  end
endmodule
